/* File: hw/hsal_top.sv */
// host serial async link: full-duplex uart acting as the terminal end
// assumes a 40 MHz clock, a synchronous reset and one host on the lines
`timescale 1ns/1ps
module hsal_top (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic [1:0] baud_sel_in,      // rate select code
  input  wire logic       eight_bits_in,    // 1: 8 data bits, 0: 7
  input  wire logic [1:0] parity_sel_in,    // parity mode code
  input  wire logic [7:0] tx_data_in,       // word to send
  input  wire logic       tx_valid_in,      // word offered
  output logic            tx_ready_out,     // word taken
  output logic [7:0]      rx_data_out,      // received word
  output logic            rx_valid_out,     // received word valid
  output logic            rx_error_out,     // parity or stop fault
  input  wire logic       rx_ready_in,      // user takes word
  input  wire logic       rx_line_in,       // received data pin
  output logic            tx_line_out       // transmitted data pin
);
  // oversample tick divider, one enable pulse per 1/16 bit
  logic [11:0] div_cnt;                     // divider count
  logic        tick;                        // oversample enable
  wire  [11:0] div_max =                    // selected divisor
    (baud_sel_in == hsal_pkg::SEL_19200) ? hsal_pkg::DIV_19200 :
    (baud_sel_in == hsal_pkg::SEL_9600)  ? hsal_pkg::DIV_9600  :
    (baud_sel_in == hsal_pkg::SEL_4800)  ? hsal_pkg::DIV_4800  :
                                           hsal_pkg::DIV_2400;
  wire         div_wrap = (div_cnt >= 12'(div_max - 12'h001));

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      div_cnt <= 12'h000;
      tick    <= 1'h0;
    end
    else
    begin
      div_cnt <= div_wrap ? 12'h000 : 12'(div_cnt + 12'h001);
      tick    <= div_wrap;
    end
  end

  // parity of the active data bits
  function automatic logic par_bit(input logic [7:0] d, input logic eight,
                                   input logic [1:0] mode);
    logic p;
    p = ^d[6:0] ^ (eight & d[7]);
    par_bit = (mode == hsal_pkg::PAR_ODD) ? ~p : p;
  endfunction

  // transmit side
  hsal_pkg::hsal_state_t tx_state;          // transmit phase
  logic [7:0] tx_shift;                     // word being sent
  logic [3:0] tx_tick;                      // tick within bit
  logic [2:0] tx_bit;                       // data bit index
  logic       tx_par;                       // parity to send
  wire        tx_bit_end = tick && (tx_tick == hsal_pkg::TICK_LAST);
  wire  [2:0] last_bit   = eight_bits_in ? 3'h7 : 3'h6;
  wire        has_par    = (parity_sel_in != hsal_pkg::PAR_NONE);
  wire        tx_take    = (tx_state == hsal_pkg::HSAL_IDLE) && tx_valid_in;

  // tx ready stalls the source while a frame is on the line
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      tx_ready_out <= 1'h0;
    else
      tx_ready_out <= (tx_state == hsal_pkg::HSAL_IDLE) && !tx_take;
  end

  // transmit frame sequencer
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      tx_state    <= hsal_pkg::HSAL_IDLE;
      tx_shift    <= 8'h00;
      tx_tick     <= 4'h0;
      tx_bit      <= 3'h0;
      tx_par      <= 1'h0;
      tx_line_out <= hsal_pkg::LINE_IDLE;
    end
    else
    begin
      if (tick)
        tx_tick <= 4'(tx_tick + 4'h1);
      unique case (tx_state)
        hsal_pkg::HSAL_IDLE:
        begin
          tx_line_out <= hsal_pkg::LINE_IDLE;
          if (tx_valid_in && tx_ready_out)
          begin
            tx_shift    <= tx_data_in;
            tx_par      <= par_bit(tx_data_in, eight_bits_in, parity_sel_in);
            tx_tick     <= 4'h0;
            tx_state    <= hsal_pkg::HSAL_START;
            tx_line_out <= hsal_pkg::LINE_START;
          end
        end
        hsal_pkg::HSAL_START:
          if (tx_bit_end)
          begin
            tx_bit      <= 3'h0;
            tx_line_out <= tx_shift[0];
            tx_state    <= hsal_pkg::HSAL_DATA;
          end
        hsal_pkg::HSAL_DATA:
          if (tx_bit_end)
          begin
            if (tx_bit == last_bit)
            begin
              tx_line_out <= has_par ? tx_par : hsal_pkg::LINE_IDLE;
              tx_state    <= has_par ? hsal_pkg::HSAL_PARITY : hsal_pkg::HSAL_STOP;
            end
            else
            begin
              tx_bit      <= 3'(tx_bit + 3'h1);
              tx_line_out <= tx_shift[3'(tx_bit + 3'h1)];
            end
          end
        hsal_pkg::HSAL_PARITY:
          if (tx_bit_end)
          begin
            tx_line_out <= hsal_pkg::LINE_IDLE;
            tx_state    <= hsal_pkg::HSAL_STOP;
          end
        hsal_pkg::HSAL_STOP:
          if (tx_bit_end)
            tx_state <= hsal_pkg::HSAL_IDLE;
        default:
          tx_state <= hsal_pkg::HSAL_IDLE;
      endcase
    end
  end

  // receive side: pin synchroniser, the only modem-free input used
  logic rx_meta;                            // first stage
  logic rx_sync;                            // second stage
  logic [2:0] rx_hist;                      // last three samples
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      rx_meta <= hsal_pkg::LINE_IDLE;
      rx_sync <= hsal_pkg::LINE_IDLE;
      rx_hist <= 3'h7;
    end
    else
    begin
      rx_meta <= rx_line_in;
      rx_sync <= rx_meta;
      if (tick)
        rx_hist <= {rx_hist[1:0], rx_sync};
    end
  end

  // majority of three samples rejects single glitches
  wire rx_vote = (rx_hist[0] & rx_hist[1]) | (rx_hist[1] & rx_hist[2]) |
                 (rx_hist[0] & rx_hist[2]);

  hsal_pkg::hsal_state_t rx_state;          // receive phase
  logic [3:0] rx_tick;                      // tick within bit
  logic [2:0] rx_bit;                       // data bit index
  logic [7:0] rx_shift;                     // assembled word
  logic       rx_par_bad;                   // parity mismatch seen
  logic       rx_push;                      // word to buffer
  logic [7:0] rx_word;                      // word to push, error kept in rx_word_err
  logic       rx_word_err;                  // error of pushed word
  wire        rx_mid = tick && (rx_tick == hsal_pkg::TICK_MID);
  wire        buf_ready;                    // buffer has room

  // receive frame sequencer; a full buffer drops the word, and no error flag records the drop
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      rx_state    <= hsal_pkg::HSAL_IDLE;
      rx_tick     <= 4'h0;
      rx_bit      <= 3'h0;
      rx_shift    <= 8'h00;
      rx_par_bad  <= 1'h0;
      rx_push     <= 1'h0;
      rx_word     <= 8'h00;
      rx_word_err <= 1'h0;
    end
    else
    begin
      rx_push <= 1'h0;
      if (tick)
        rx_tick <= 4'(rx_tick + 4'h1);
      unique case (rx_state)
        hsal_pkg::HSAL_IDLE:
          if (tick && (rx_sync == hsal_pkg::LINE_START))
          begin
            rx_tick  <= 4'h1;
            rx_state <= hsal_pkg::HSAL_START;
          end
        hsal_pkg::HSAL_START:
          if (rx_mid)
          begin
            if (rx_vote == hsal_pkg::LINE_START)
            begin
              rx_tick    <= 4'h0;
              rx_bit     <= 3'h0;
              rx_shift   <= 8'h00;
              rx_par_bad <= 1'h0;
              rx_state   <= hsal_pkg::HSAL_DATA;
            end
            else
              rx_state <= hsal_pkg::HSAL_IDLE;
          end
        hsal_pkg::HSAL_DATA:
          if (tick && (rx_tick == hsal_pkg::TICK_LAST))
          begin
            rx_shift[rx_bit] <= rx_vote;
            if (rx_bit == last_bit)
              rx_state <= has_par ? hsal_pkg::HSAL_PARITY : hsal_pkg::HSAL_STOP;
            else
              rx_bit <= 3'(rx_bit + 3'h1);
          end
        hsal_pkg::HSAL_PARITY:
          if (tick && (rx_tick == hsal_pkg::TICK_LAST))
          begin
            rx_par_bad <= (rx_vote != par_bit(rx_shift, eight_bits_in,
                                              parity_sel_in));
            rx_state   <= hsal_pkg::HSAL_STOP;
          end
        hsal_pkg::HSAL_STOP:
          if (tick && (rx_tick == hsal_pkg::TICK_LAST))
          begin
            rx_push     <= buf_ready;
            rx_word     <= rx_shift;
            rx_word_err <= rx_par_bad || (rx_vote != hsal_pkg::LINE_IDLE);
            rx_state    <= hsal_pkg::HSAL_IDLE;
          end
        default:
          rx_state <= hsal_pkg::HSAL_IDLE;
      endcase
    end
  end

  // error travels with each word in a parallel two-slot flag store
  logic [1:0] err_q;                        // error flags per slot
  logic       err_wr;                       // flag write slot
  logic       err_rd;                       // flag read slot
  logic [7:0] buf_data;                     // buffer head word
  logic       buf_valid;                    // buffer head valid
  // pop only a word already shown, so a consumer holding ready loses nothing
  wire        pop = rx_ready_in && rx_valid_out && buf_valid;

  hsal_skid u_rx_buf (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .in_data_in    (rx_word),
    .in_valid_in   (rx_push),
    .in_ready_out  (buf_ready),
    .out_data_out  (buf_data),
    .out_valid_out (buf_valid),
    .out_ready_in  (pop)
  );

  // error flag slots follow buffer pointers
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      err_q  <= 2'h0;
      err_wr <= 1'h0;
      err_rd <= 1'h0;
    end
    else
    begin
      if (rx_push && buf_ready)
      begin
        err_q[err_wr] <= rx_word_err;
        err_wr        <= ~err_wr;
      end
      if (pop)
        err_rd <= ~err_rd;
    end
  end

  // registered output copy of buffer head; updates each cycle
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      rx_data_out  <= 8'h00;
      rx_valid_out <= 1'h0;
      rx_error_out <= 1'h0;
    end
    else
    begin
      rx_data_out  <= eight_bits_in ? buf_data : {1'b0, buf_data[6:0]};
      rx_valid_out <= buf_valid && !pop;
      rx_error_out <= buf_valid && !pop && err_q[err_rd];
    end
  end

  chk_tx_idle_high : assert property (@(posedge clk_in) disable iff (reset_in)
    (tx_state == hsal_pkg::HSAL_IDLE && $past(tx_state) == hsal_pkg::HSAL_STOP)
      |-> tx_line_out == hsal_pkg::LINE_IDLE) else $error("stop bit not high");
  chk_tx_start_low : assert property (@(posedge clk_in) disable iff (reset_in)
    (tx_state == hsal_pkg::HSAL_START) |-> tx_line_out == hsal_pkg::LINE_START)
    else $error("start bit not low");
  chk_tx_no_parity : assert property (@(posedge clk_in) disable iff (reset_in)
    (parity_sel_in == hsal_pkg::PAR_NONE && $stable(parity_sel_in))
      |-> tx_state != hsal_pkg::HSAL_PARITY) else $error("parity sent when off");
  chk_rx_glitch_reject : assert property (@(posedge clk_in) disable iff (reset_in)
    (rx_state == hsal_pkg::HSAL_START && rx_mid && rx_vote)
      |=> rx_state == hsal_pkg::HSAL_IDLE) else $error("glitch accepted as start");
  chk_duplex_tx_busy : assert property (@(posedge clk_in) disable iff (reset_in)
    (tx_state != hsal_pkg::HSAL_IDLE) |-> !tx_ready_out)
    else $error("ready while sending");
  chk_tick_rate : assert property (@(posedge clk_in) disable iff (reset_in)
    (tick && baud_sel_in == hsal_pkg::SEL_19200 && $stable(baud_sel_in))
      |=> !tick [*8]) else $error("tick too fast");
  chk_bit_count : assert property (@(posedge clk_in) disable iff (reset_in)
    (tx_state == hsal_pkg::HSAL_DATA) |-> tx_bit <= last_bit)
    else $error("data bit index overflow");
  chk_rx_stop_err : assert property (@(posedge clk_in) disable iff (reset_in)
    (rx_state == hsal_pkg::HSAL_STOP && tick && rx_tick == hsal_pkg::TICK_LAST
      && !rx_vote) |=> rx_word_err) else $error("low stop not flagged");
endmodule

/* File: hw/hsal_pkg.sv */
// package for the host serial async link: timing counts and config codes
// assumes a 40 MHz system clock and 16x oversampling of each bit
package hsal_pkg;
  localparam int unsigned CLK_HZ        = 40000000;        // system clock rate
  localparam int unsigned OVERSAMPLE    = 16;              // ticks per bit
  localparam int unsigned BAUD_19200    = 19200;           // fastest rate
  localparam int unsigned BAUD_9600     = 9600;
  localparam int unsigned BAUD_4800     = 4800;
  localparam int unsigned BAUD_2400     = 2400;            // slowest rate
  // oversample tick divisors, rounded down
  localparam logic [11:0] DIV_19200 = 12'(CLK_HZ / (BAUD_19200 * OVERSAMPLE));
  localparam logic [11:0] DIV_9600  = 12'(CLK_HZ / (BAUD_9600 * OVERSAMPLE));
  localparam logic [11:0] DIV_4800  = 12'(CLK_HZ / (BAUD_4800 * OVERSAMPLE));
  localparam logic [11:0] DIV_2400  = 12'(CLK_HZ / (BAUD_2400 * OVERSAMPLE));
  localparam logic [3:0]  TICK_MID   = 4'h7;               // mid-bit sample tick
  localparam logic [3:0]  TICK_LAST  = 4'hF;               // last tick of a bit
  // baud select codes
  localparam logic [1:0]  SEL_19200 = 2'h0;
  localparam logic [1:0]  SEL_9600  = 2'h1;
  localparam logic [1:0]  SEL_4800  = 2'h2;
  localparam logic [1:0]  SEL_2400  = 2'h3;
  // parity codes
  localparam logic [1:0]  PAR_NONE  = 2'h0;
  localparam logic [1:0]  PAR_ODD   = 2'h1;
  localparam logic [1:0]  PAR_EVEN  = 2'h2;
  localparam logic        LINE_IDLE = 1'h1;                // idle/stop level
  localparam logic        LINE_START = 1'h0;               // start level
  typedef enum logic [2:0] {
    HSAL_IDLE   = 3'h0,
    HSAL_START  = 3'h1,
    HSAL_DATA   = 3'h2,
    HSAL_PARITY = 3'h3,
    HSAL_STOP   = 3'h4
  } hsal_state_t;
endpackage

/* File: hw/hsal_skid.sv */
// two-entry buffer with valid/ready on both sides
// assumes single clock, synchronous active-high reset
`timescale 1ns/1ps
module hsal_skid (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic [7:0] in_data_in,
  input  wire logic       in_valid_in,
  output logic            in_ready_out,
  output logic [7:0]      out_data_out,
  output logic            out_valid_out,
  input  wire logic       out_ready_in
);
  logic [7:0] mem [2];     // two storage slots
  logic       wr_ptr;      // next slot to fill
  logic       rd_ptr;      // next slot to drain
  logic [1:0] count;       // entries held
  wire        push = in_valid_in && (count != 2'h2);
  wire        pop  = (count != 2'h0) && out_ready_in;

  assign in_ready_out  = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign out_data_out  = mem[rd_ptr];

  // pointers and fill count
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      wr_ptr <= 1'h0;
      rd_ptr <= 1'h0;
      count  <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= 2'(count + {1'b0, push} - {1'b0, pop});
    end
  end

  // storage, no reset needed for data
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem[wr_ptr] <= in_data_in;
  end

  chk_skid_no_overfill : assert property (@(posedge clk_in) disable iff (reset_in)
    count <= 2'h2) else $error("buffer count above two");
endmodule

/* File: verif/hsal_host_model.sv */
// host-side serial port model facing the link's two data pins
// assumes the bench gives it the same rate and format as the device
`timescale 1ns/1ps
module hsal_host_model (
  input  wire logic       clk_in,
  input  wire logic [1:0] baud_sel_in,    // rate code, shared
  input  wire logic       eight_bits_in,  // 1: 8 data bits
  input  wire logic [1:0] parity_sel_in,  // parity code
  input  wire logic       line_in,        // device transmit pin
  output logic            line_out,       // device receive pin
  input  wire logic       send_in,        // start one frame
  input  wire logic [7:0] send_data_in,   // word to send
  input  wire logic       bad_par_in,     // flip the parity bit
  input  wire logic       bad_stop_in,    // send a low stop bit
  output logic            busy_out,       // frame on the wire
  output int              got_cnt_out,    // frames heard
  output logic [7:0]      got_data_out,   // last word heard
  output logic            got_par_out,    // last parity bit heard
  output logic            got_stop_out    // last stop level heard
);
  int         bc;   // clocks per bit
  int         nb;   // data bits per character
  logic [7:0] sh;   // outgoing word
  logic [7:0] rd;   // incoming word
  // both ends run the same rate
  assign bc = 16 * int'(baud_sel_in == hsal_pkg::SEL_19200 ? hsal_pkg::DIV_19200 :
                        baud_sel_in == hsal_pkg::SEL_9600  ? hsal_pkg::DIV_9600  :
                        baud_sel_in == hsal_pkg::SEL_4800  ? hsal_pkg::DIV_4800  :
                        hsal_pkg::DIV_2400);
  assign nb = eight_bits_in ? 8 : 7;
  // parity over the data bits only; odd flips the xor
  function automatic logic par_of(input logic [7:0] d);
    par_of = (^(eight_bits_in ? d : {1'b0, d[6:0]})) ^ (parity_sel_in == hsal_pkg::PAR_ODD);
  endfunction
  // idle-high line, no modem lines exist on either end
  initial
  begin
    line_out = hsal_pkg::LINE_IDLE;
    busy_out = 1'b0;
    got_cnt_out = 0;
  end
  // transmit toward the device; faults only when the bench asks
  always @(posedge clk_in)
    if (send_in && !busy_out)
    begin
      busy_out <= 1'b1;
      sh = send_data_in;
      line_out <= hsal_pkg::LINE_START;
      repeat (bc) @(posedge clk_in);
      for (int i = 0; i < nb; i++)
      begin
        line_out <= sh[i];
        repeat (bc) @(posedge clk_in);
      end
      // parity present unless none chosen
      if (parity_sel_in != hsal_pkg::PAR_NONE)
      begin
        line_out <= par_of(sh) ^ bad_par_in;
        repeat (bc) @(posedge clk_in);
      end
      // a broken stop is one low bit before idle
      if (bad_stop_in)
      begin
        line_out <= hsal_pkg::LINE_START;
        repeat (bc) @(posedge clk_in);
      end
      line_out <= hsal_pkg::LINE_IDLE;
      repeat (bc) @(posedge clk_in);
      busy_out <= 1'b0;
    end
  // receive from the device, sampling mid-bit after the start edge
  always
  begin
    @(negedge line_in);
    rd = 8'h00;
    repeat (bc / 2) @(posedge clk_in);
    for (int i = 0; i < nb; i++)
    begin
      repeat (bc) @(posedge clk_in);
      rd[i] = line_in;
    end
    // parity slot only when enabled
    if (parity_sel_in != hsal_pkg::PAR_NONE)
    begin
      repeat (bc) @(posedge clk_in);
      got_par_out = line_in;
    end
    repeat (bc) @(posedge clk_in);
    got_stop_out = line_in;
    got_data_out = rd;
    got_cnt_out++;
  end
endmodule

/* File: verif/test_host_serial_async_link.sv */
// self-checking bench: device transmit and receive against a host model
// assumes a 40 MHz clock; frames at the fastest rate keep the run short
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module test_host_serial_async_link;
  logic       clk_in, reset_in;              // clock and reset
  logic [1:0] baud_sel, parity_sel;          // shared config
  logic       eight_bits;
  logic [7:0] tx_data, rx_data, send_data, got_data;
  logic       tx_valid, tx_ready, rx_valid, rx_error, rx_ready;
  logic       rx_line, tx_line;              // the two data pins
  logic       send, bad_par, bad_stop, busy, got_par, got_stop;
  int         got_cnt, error_cnt, n_checks, cnt, n0;
  hsal_top hsal_top_inst (.clk_in(clk_in), .reset_in(reset_in), .baud_sel_in(baud_sel),
    .eight_bits_in(eight_bits), .parity_sel_in(parity_sel), .tx_data_in(tx_data),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .rx_data_out(rx_data),
    .rx_valid_out(rx_valid), .rx_error_out(rx_error), .rx_ready_in(rx_ready),
    .rx_line_in(rx_line), .tx_line_out(tx_line));
  hsal_host_model hsal_host_model_inst (.clk_in(clk_in), .baud_sel_in(baud_sel),
    .eight_bits_in(eight_bits), .parity_sel_in(parity_sel), .line_in(tx_line),
    .line_out(rx_line), .send_in(send), .send_data_in(send_data), .bad_par_in(bad_par),
    .bad_stop_in(bad_stop), .busy_out(busy), .got_cnt_out(got_cnt), .got_data_out(got_data),
    .got_par_out(got_par), .got_stop_out(got_stop));
  // free-running clock
  always #12.5 clk_in = ~clk_in;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // verdict and end of run
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // config is level, changed only between frames
  task automatic cfg(input logic [1:0] b, input logic e, input logic [1:0] p);
    @(posedge clk_in);
    baud_sel <= b;
    eight_bits <= e;
    parity_sel <= p;
  endtask
  // offer a word and optionally start a host frame on the same edge
  task automatic start(input logic [7:0] td, rd, input logic bp, bs, hs);
    int k;
    k = 0;
    while (tx_ready !== 1'b1 && k < 200)
    begin
      @(negedge clk_in);
      k++;
    end
    @(posedge clk_in);
    tx_data <= td;
    tx_valid <= 1'b1;
    send_data <= rd;
    send <= hs;
    bad_par <= bp;
    bad_stop <= bs;
    @(posedge clk_in);
    tx_valid <= 1'b0;
    send <= 1'b0;
  endtask
  // wait for both directions to finish, then let the receive push land
  task automatic finish_frame;
    int k;
    k = 0;
    while ((got_cnt == n0 || tx_ready !== 1'b1 || busy) && k < 30000)
    begin
      @(negedge clk_in);
      k++;
    end
    `CHK(k < 30000, 1'b1)
    cyc(100);
    @(negedge clk_in);
  endtask
  // take one buffered word; ready only while valid
  task automatic pop(input logic [7:0] d, input logic e);
    @(negedge clk_in);
    `CHK(rx_valid, 1'b1)
    `CHK(rx_data, d)
    `CHK(rx_error, e)
    @(posedge clk_in);
    rx_ready <= 1'b1;
    @(posedge clk_in);
    rx_ready <= 1'b0;
    cyc(3);
  endtask
  // main sequence
  initial
  begin
    clk_in = 1'b0;
    reset_in = 1'b1;
    {baud_sel, parity_sel, eight_bits, tx_data, tx_valid, rx_ready} = '0;
    {send, send_data, bad_par, bad_stop} = '0;
    error_cnt = 0;
    n_checks = 0;
    cyc(20);
    @(negedge clk_in);
    `CHK(tx_line, 1'b1)
    `CHK(rx_valid, 1'b0)
    @(posedge clk_in);
    reset_in <= 1'b0;
    $display("test reset done");
    // 8 data bits, no parity, both directions at once
    cfg(hsal_pkg::SEL_19200, 1'b1, hsal_pkg::PAR_NONE);
    n0 = got_cnt;
    start(8'hA5, 8'h3C, 1'b0, 1'b0, 1'b1);
    finish_frame();
    `CHK(got_data, 8'hA5)
    `CHK(got_stop, 1'b1)
    `CHK(rx_data, 8'h3C)
    $display("test 8n1 done");
    // 7 data bits odd parity; host parity broken; word 1 still unread
    cfg(hsal_pkg::SEL_19200, 1'b0, hsal_pkg::PAR_ODD);
    n0 = got_cnt;
    start(8'hD5, 8'h2A, 1'b1, 1'b0, 1'b1);
    finish_frame();
    `CHK(got_data, 8'h55)
    `CHK(got_par, 1'b1)
    $display("test 7o1 done");
    // 8 data bits even parity; host stop broken; buffer full drops it
    cfg(hsal_pkg::SEL_19200, 1'b1, hsal_pkg::PAR_EVEN);
    n0 = got_cnt;
    start(8'h81, 8'h77, 1'b0, 1'b1, 1'b1);
    finish_frame();
    `CHK(got_data, 8'h81)
    `CHK(got_par, 1'b0)
    pop(8'h3C, 1'b0);
    pop(8'h2A, 1'b1);
    @(negedge clk_in);
    `CHK(rx_valid, 1'b0)
    $display("test buffer done");
    // start bit length at every rate, cut short by reset
    for (int s = 0; s < 4; s++)
    begin
      cfg(2'(s), 1'b1, hsal_pkg::PAR_NONE);
      start(8'h01, 8'h00, 1'b0, 1'b0, 1'b0);
      // let the start bit reach the pin before counting it
      @(negedge clk_in);
      cnt = 0;
      while (tx_line === 1'b0 && cnt < 20000)
      begin
        @(negedge clk_in);
        cnt++;
      end
      n0 = 16 * int'(s == 0 ? hsal_pkg::DIV_19200 : s == 1 ? hsal_pkg::DIV_9600 :
                     s == 2 ? hsal_pkg::DIV_4800 : hsal_pkg::DIV_2400);
      // first tick after the take lands anywhere within one tick period
      `CHK(cnt > n0 - n0 / 16 && cnt <= n0, 1'b1)
      @(posedge clk_in);
      reset_in <= 1'b1;
      cyc(20);
      @(negedge clk_in);
      `CHK(tx_line, 1'b1)
      `CHK(tx_ready, 1'b0)
      @(posedge clk_in);
      reset_in <= 1'b0;
      cyc(3);
      @(negedge clk_in);
      `CHK(tx_ready, 1'b1)
    end
    $display("test rates done");
    report_and_stop();
  end
  // watchdog sized for three fast frames plus four start bits
  initial
  begin
    cyc(104000);
    error_cnt++;
    report_and_stop();
  end
endmodule
